/* File: hw/dcw_top.sv */
// Dual communication watchdog with shared tick divider and safe-state output.
// Assumes activity strobes and process data come from logic on clk_sys_in.
//
// Summary of operation
// - Two independent watchdogs, bus side and local interface, each default to 100 ms.
// - The tick divider register at 0x0400 sets the tick period of both watchdogs.
// - Each watchdog has its own count register, 0x0410 local and 0x0420 bus side.
// - The bus-side watchdog restarts on each good exchange and trips after its timeout.
// - Bus-side expiry leaves the slave's communication state untouched.
// - A tripped bus-side watchdog stays tripped until a good process data access or a bus-side count of zero.
// - The local watchdog trips when the local interface is silent past its timeout.
// - A tick lasts divider plus 2 base ticks of 40 ns, or one 100 ns clock at divider 0; timeout is tick times count.
// - Divider resets to 2498 and bus-side count to 1000, giving 100 ms.
// - A bus-side count of zero disables that watchdog and never forces safe state.
// - On expiry the outputs are driven to the preset safe value.
`timescale 1ns/1ps
module dcw_top (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire dcw_pkg::dcw_reg_req_s reg_req_in,
	output dcw_pkg::dcw_reg_rsp_s reg_rsp_out,
	input wire logic bus_exchange_ok_in,
	input wire logic local_access_in,
	input wire logic [15:0] process_data_in,
	input wire logic [15:0] safe_value_in,
	output logic [15:0] output_out,
	output dcw_pkg::dcw_status_s status_out
);

	logic [15:0] div;
	logic [15:0] next_div;
	logic [15:0] bus_count;
	logic [15:0] next_bus_count;
	logic [15:0] local_count;
	logic [15:0] next_local_count;
	dcw_pkg::dcw_reg_rsp_s rsp;
	dcw_pkg::dcw_reg_rsp_s next_rsp;
	logic div_write;

	// Register writes and registered read answers.
	always_comb begin
		next_div = div;
		next_bus_count = bus_count;
		next_local_count = local_count;
		div_write = 1'b0;
		if (reg_req_in.wr) begin
			case (reg_req_in.addr)
				dcw_pkg::REG_TICK_DIVIDER: begin
					next_div = reg_req_in.wdata;
					div_write = 1'b1;
				end
				dcw_pkg::REG_LOCAL_COUNT: next_local_count = reg_req_in.wdata;
				dcw_pkg::REG_BUS_COUNT: next_bus_count = reg_req_in.wdata;
				default: next_div = div;
			endcase
		end
		next_rsp.valid = reg_req_in.rd;
		case (reg_req_in.addr)
			dcw_pkg::REG_TICK_DIVIDER: next_rsp.data = div;
			dcw_pkg::REG_LOCAL_COUNT: next_rsp.data = local_count;
			dcw_pkg::REG_BUS_COUNT: next_rsp.data = bus_count;
			default: next_rsp.data = 16'h0000;
		endcase
		if (!reg_req_in.rd) begin
			next_rsp.data = 16'h0000;
		end
	end

	// Register storage with documented reset values.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div <= dcw_pkg::DIV_RESET;
			bus_count <= dcw_pkg::BUS_COUNT_RESET;
			local_count <= dcw_pkg::LOCAL_COUNT_RESET;
			rsp <= '0;
		end else begin
			div <= next_div;
			bus_count <= next_bus_count;
			local_count <= next_local_count;
			rsp <= next_rsp;
		end
	end

	assign reg_rsp_out = rsp;

	logic [dcw_pkg::ACC_W-1:0] acc;
	logic [dcw_pkg::ACC_W-1:0] next_acc;
	logic [dcw_pkg::ACC_W-1:0] acc_sum;
	logic [dcw_pkg::ACC_W-1:0] acc_rem;
	logic [dcw_pkg::ACC_W-1:0] thr;
	logic tick_now;
	logic tick;
	logic next_tick;

	// Fractional tick divider in 20 ns quanta: the clock adds 5, a base tick weighs 2.
	// A divider of 0 asks for 80 ns ticks, faster than the clock, so they saturate at one
	// per cycle.
	// The remainder is clamped below one tick, so saturation or a smaller divider never
	// leaves a backlog that would fire a burst of early ticks later.
	always_comb begin
		thr = ({3'h0, div} + dcw_pkg::DIV_OFFSET) * dcw_pkg::BASE_STEP;
		acc_sum = acc + dcw_pkg::CLK_STEP;
		acc_rem = acc_sum - thr;
		tick_now = (acc_sum >= thr);
		if (!tick_now) begin
			next_acc = acc_sum;
		end else if (acc_rem >= thr) begin
			next_acc = thr - 19'h00001;
		end else begin
			next_acc = acc_rem;
		end
		next_tick = tick_now;
	end

	// Tick divider state.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc <= '0;
			tick <= 1'b0;
		end else begin
			acc <= next_acc;
			tick <= next_tick;
		end
	end

	logic bus_expired;
	logic local_expired;

	// Bus-side watchdog, restarted by each good process data exchange.
	dcw_timeout u_bus_wd (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.tick_in(tick),
		.kick_in(bus_exchange_ok_in),
		.count_in(bus_count),
		.expired_out(bus_expired)
	);

	// Local-interface watchdog, restarted by any local processor access.
	dcw_timeout u_local_wd (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.tick_in(tick),
		.kick_in(local_access_in),
		.count_in(local_count),
		.expired_out(local_expired)
	);

	logic safe;
	logic [15:0] out_q;
	logic [15:0] next_out;

	// Output stage: expiry swaps in the safe value, nothing else reacts to it.
	// The communication state machine never sees the expiry flags.
	always_comb begin
		safe = bus_expired || local_expired;
		next_out = safe ? safe_value_in : process_data_in;
	end

	// Output register.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_q <= 16'h0000;
		end else begin
			out_q <= next_out;
		end
	end

	assign output_out = out_q;
	assign status_out.bus_expired = bus_expired;
	assign status_out.local_expired = local_expired;
	assign status_out.safe_active = safe;

	logic [17:0] gap;
	logic gap_valid;

	// Helper counting cycles between ticks, valid while the divider is steady.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gap <= 18'h00001;
			gap_valid <= 1'b0;
		end else begin
			if (tick_now) begin
				gap <= 18'h00001;
			end else if (gap != 18'h3FFFF) begin
				gap <= gap + 18'h00001;
			end
			if (div_write) begin
				gap_valid <= 1'b0;
			end else if (tick_now) begin
				gap_valid <= (next_acc < dcw_pkg::CLK_STEP);
			end
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	a_tick_period: assert property (
		tick_now && gap_valid && div != 16'h0000 |->
		(22'(gap) * 22'(dcw_pkg::CLK_STEP) + 22'h000004 >= 22'(thr)) &&
		(22'(gap) * 22'(dcw_pkg::CLK_STEP) < 22'(thr) + 22'(dcw_pkg::CLK_STEP)))
		else $error("Watchdog tick spacing does not match the divider.");

	a_div_write_takes: assert property (
		reg_req_in.wr && reg_req_in.addr == dcw_pkg::REG_TICK_DIVIDER |=>
		div == $past(reg_req_in.wdata))
		else $error("Divider write not stored.");

	a_bus_count_read: assert property (
		reg_req_in.rd && reg_req_in.addr == dcw_pkg::REG_BUS_COUNT |=>
		reg_rsp_out.valid && reg_rsp_out.data == $past(bus_count))
		else $error("Bus count readback wrong.");

	a_bus_kick_clears: assert property (
		bus_exchange_ok_in |=> !status_out.bus_expired)
		else $error("Bus watchdog not cleared by good exchange.");

	a_zero_disables: assert property (
		bus_count == 16'h0000 |=> !status_out.bus_expired)
		else $error("Disabled bus watchdog expired.");

	a_safe_output: assert property (
		safe |=> output_out == $past(safe_value_in))
		else $error("Safe value not driven on expiry.");

	a_normal_output: assert property (
		!safe |=> output_out == $past(process_data_in))
		else $error("Process data not passed through.");

	a_local_kick_clears: assert property (
		local_access_in ##1 !local_access_in |-> !status_out.local_expired)
		else $error("Local watchdog not cleared by access.");

endmodule

/* File: inc/dcw_pkg.sv */
// Constants and types shared by the dual communication watchdog.
// Assumes a single 10 MHz system clock and 16-bit register data.
package dcw_pkg;

	// Register offsets on the register access port.
	localparam logic [15:0] REG_TICK_DIVIDER = 16'h0400;
	localparam logic [15:0] REG_LOCAL_COUNT = 16'h0410;
	localparam logic [15:0] REG_BUS_COUNT = 16'h0420;

	// Values after reset.
	localparam logic [15:0] DIV_RESET = 16'h09C2;
	localparam logic [15:0] BUS_COUNT_RESET = 16'h03E8;
	localparam logic [15:0] LOCAL_COUNT_RESET = 16'h03E8;

	// Timing: one watchdog tick is (divider + 2) base ticks of 40 ns, or one clock cycle at divider 0.
	localparam int CLK_PERIOD_NS = 100;
	localparam int BASE_TICK_NS = 40;
	localparam int QUANTUM_NS = 20;
	localparam int ACC_W = 19;
	localparam logic [ACC_W-1:0] CLK_STEP = ACC_W'(CLK_PERIOD_NS / QUANTUM_NS);
	localparam logic [ACC_W-1:0] BASE_STEP = ACC_W'(BASE_TICK_NS / QUANTUM_NS);
	localparam logic [ACC_W-1:0] DIV_OFFSET = 19'h00002;

	// One register access request, taken in the cycle it is presented.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dcw_reg_req_s;

	// Read answer, valid for one cycle.
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} dcw_reg_rsp_s;

	// Watchdog status seen by the rest of the controller.
	typedef struct packed {
		logic bus_expired;
		logic local_expired;
		logic safe_active;
	} dcw_status_s;

endpackage

/* File: hw/dcw_timeout.sv */
// One watchdog timer counting shared ticks since the last traffic event.
// Assumes tick_in and kick_in are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module dcw_timeout (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic tick_in,
	input wire logic kick_in,
	input wire logic [15:0] count_in,
	output logic expired_out
);

	logic [15:0] elapsed;
	logic [15:0] next_elapsed;
	logic expired;
	logic next_expired;

	// Traffic restarts the timer and clears expiry; a zero count disables it.
	always_comb begin
		next_elapsed = elapsed;
		next_expired = expired;
		if (kick_in) begin
			next_elapsed = 16'h0000;
			next_expired = 1'b0;
		end else if (count_in == 16'h0000) begin
			next_elapsed = 16'h0000;
			next_expired = 1'b0;
		end else if (tick_in && !expired) begin
			next_elapsed = elapsed + 16'h0001;
			if (elapsed + 16'h0001 >= count_in) begin
				next_expired = 1'b1;
			end
		end
	end

	// Timer state registers.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			elapsed <= 16'h0000;
			expired <= 1'b0;
		end else begin
			elapsed <= next_elapsed;
			expired <= next_expired;
		end
	end

	assign expired_out = expired;

	// Expiry appears only on the tick that completes the programmed count.
	a_expire_at_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(expired) |-> $past(tick_in) && ($past(elapsed) + 16'h0001 == $past(count_in)))
		else $error("Watchdog expired at the wrong count.");

	// Once set, expiry holds until traffic or disable.
	a_expired_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		expired && !kick_in && count_in != 16'h0000 |=> expired)
		else $error("Watchdog expiry dropped without traffic.");

endmodule

/* File: tb/dcw_partner.sv */
// Far-side model: fieldbus master exchanges and local processor accesses.
// Assumes the bench commands traffic on the same clock.
`timescale 1ns/1ps
module dcw_partner (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic bus_cmd_in,
	input wire logic local_cmd_in,
	output logic bus_exchange_ok_out,
	output logic local_access_out
);
	// Each commanded cycle becomes one traffic pulse a cycle later.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_exchange_ok_out <= 1'b0;
			local_access_out <= 1'b0;
		end else begin
			bus_exchange_ok_out <= bus_cmd_in;
			local_access_out <= local_cmd_in;
		end
	end
endmodule

/* File: tb/dcw_top_tb.sv */
// Self-checking bench: register port, both timeouts, safe output, disable.
// Assumes the far-side model turns kick commands into traffic pulses.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((ex) !== (got)) begin err_total++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module dcw_top_tb;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic bus_cmd = 1'b0;
	logic local_cmd = 1'b0;
	logic bus_ok;
	logic local_acc;
	logic [15:0] pdata = 16'h0000;
	logic [15:0] safe = 16'h0000;
	logic [15:0] outv;
	dcw_pkg::dcw_reg_req_s req = '0;
	dcw_pkg::dcw_reg_rsp_s rsp;
	dcw_pkg::dcw_status_s st;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	int mdl[int];

	dcw_top dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_req_in(req),
		.reg_rsp_out(rsp), .bus_exchange_ok_in(bus_ok), .local_access_in(local_acc),
		.process_data_in(pdata), .safe_value_in(safe), .output_out(outv), .status_out(st));
	dcw_partner partner (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bus_cmd_in(bus_cmd),
		.local_cmd_in(local_cmd), .bus_exchange_ok_out(bus_ok), .local_access_out(local_acc));

	// Clock with a 100 ns period.
	initial forever #50 clk_sys_in = ~clk_sys_in;

	// Write one register and track it in the model; unmapped places stay absent.
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge clk_sys_in);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk_sys_in);
		req <= '0;
		if (mdl.exists(int'(a))) mdl[int'(a)] = int'(v);
	endtask

	// Read one register; the answer stands for the cycle after the request.
	task automatic rd(input logic [15:0] a);
		logic [15:0] ex;
		ex = mdl.exists(int'(a)) ? 16'(mdl[int'(a)]) : 16'h0000;
		@(posedge clk_sys_in);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_sys_in);
		req <= '0;
		#1;
		`CHK("read", {1'b1, ex}, {rsp.valid, rsp.data})
	endtask

	// Hold or drop the far side's traffic for one watchdog.
	task automatic kick(input bit bus, input logic v);
		@(posedge clk_sys_in);
		if (bus) bus_cmd <= v;
		else local_cmd <= v;
	endtask

	// Configure one watchdog while traffic runs, stop traffic, follow expiry and recovery.
	task automatic run_dog(input bit bus, input int d, input int n);
		int p;
		int lo;
		int hi;
		int k;
		p = (d + 2) * 40 < 100 ? 100 : (d + 2) * 40;
		lo = ((n - 1) * p) / 100;
		hi = (n * p + 99) / 100 + 3;
		kick(bus, 1'b1);
		pdata <= 16'($urandom()) & 16'hFFFE;
		safe <= 16'($urandom()) | 16'h0001;
		wr(bus ? dcw_pkg::REG_LOCAL_COUNT : dcw_pkg::REG_BUS_COUNT, 16'h0000);
		wr(dcw_pkg::REG_TICK_DIVIDER, 16'(d));
		wr(bus ? dcw_pkg::REG_BUS_COUNT : dcw_pkg::REG_LOCAL_COUNT, 16'(n));
		kick(bus, 1'b0);
		k = 0;
		while (k < hi && (bus ? st.bus_expired : st.local_expired) !== 1'b1) begin
			@(posedge clk_sys_in);
			#1;
			k++;
		end
		`CHK("expired", 1'b1, bus ? st.bus_expired : st.local_expired)
		`CHK("not_early", 1'b1, k >= lo)
		@(posedge clk_sys_in);
		#1;
		`CHK("safe_out", {1'b1, safe}, {st.safe_active, outv})
		repeat (6) @(posedge clk_sys_in);
		#1;
		`CHK("held", 1'b1, bus ? st.bus_expired : st.local_expired)
		kick(bus, 1'b1);
		repeat (4) @(posedge clk_sys_in);
		#1;
		`CHK("cleared", 1'b0, bus ? st.bus_expired : st.local_expired)
		`CHK("normal_out", pdata, outv)
	endtask

	// Report the counts and the verdict, then end the run.
	task automatic close_out();
		$display("mismatches %0d of %0d checks", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		void'($urandom(58004));
		mdl[int'(dcw_pkg::REG_TICK_DIVIDER)] = int'(dcw_pkg::DIV_RESET);
		mdl[int'(dcw_pkg::REG_LOCAL_COUNT)] = int'(dcw_pkg::LOCAL_COUNT_RESET);
		mdl[int'(dcw_pkg::REG_BUS_COUNT)] = int'(dcw_pkg::BUS_COUNT_RESET);
		repeat (5) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		// Startup with download switched off writes nothing, so reset values stay.
		rd(dcw_pkg::REG_TICK_DIVIDER);
		rd(dcw_pkg::REG_LOCAL_COUNT);
		rd(dcw_pkg::REG_BUS_COUNT);
		// Random values, the top of the count range and an unmapped place.
		foreach (mdl[a]) begin
			wr(16'(a), 16'($urandom()));
			rd(16'(a));
		end
		wr(dcw_pkg::REG_BUS_COUNT, 16'hFFFF);
		rd(dcw_pkg::REG_BUS_COUNT);
		wr(16'h0404, 16'h5A5A);
		rd(16'h0404);
		for (int i = 0; i < 8; i++) begin
			run_dog(i[0], i < 2 ? 0 : $urandom_range(10, 0), $urandom_range(5, 1));
		end
		// Both counts zero: silence must never force the safe value.
		kick(1'b1, 1'b0);
		kick(1'b0, 1'b0);
		wr(dcw_pkg::REG_BUS_COUNT, 16'h0000);
		wr(dcw_pkg::REG_LOCAL_COUNT, 16'h0000);
		repeat (300) @(posedge clk_sys_in);
		#1;
		`CHK("disabled", 3'b000, st)
		`CHK("live_out", pdata, outv)
		close_out();
	end

	// Cut a hang short.
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			close_out();
		end
	end
endmodule
